/* design/sep_cfg.svh */
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH
// Operation
// - An instruction starts with a high start bit while chip select is high.
// - After the start bit, two opcode bits then eight address bits shift in.
// - Read loads the register, drives a zero dummy bit, then sixteen bits.
// - Read data out changes only after a rising serial clock edge; status out follows busy.
// - Programming is disabled after reset; enable must precede erase/write.
// - Programming stays enabled until program-disable or reset.
// - Erase: chip select fall after address sets the word to ones.
// - Chip select high during programming shows busy low, then ready high.
// - Write takes sixteen data bits; chip select fall starts programming.
// - Erase-all sets every word to ones in one self-timed cycle.
// - Write-all programs the sixteen-bit pattern into every word.
// - Program-disable blocks all erase and write operations.
// - Reads behave the same whether programming is enabled or not.
// - Opcode 10 read, 11 erase, 01 write, all eight address bits used.
// - Opcode 00: top bits 11 enable, 10 erase-all, 01 write-all, 00 off.

// ****************************************************************
// Field layout and sizes
// ****************************************************************
`define SEP_OP_W        2
`define SEP_ADDR_W      8
`define SEP_DATA_W      16
`define SEP_WORDS       256
`define SEP_HDR_BITS    10
`define SEP_ERASED      16'hFFFF
`define SEP_OP_READ     2'h2
`define SEP_OP_ERASE    2'h3
`define SEP_OP_WRITE    2'h1
`define SEP_OP_EXT      2'h0
`define SEP_EXT_EN      2'h3
`define SEP_EXT_EALL    2'h2
`define SEP_EXT_WALL    2'h1
`define SEP_EXT_DIS     2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SEP_CLK_NS      4
`define SEP_PROG_NS     10000000
`define SEP_PROG_CYC    (`SEP_PROG_NS / `SEP_CLK_NS)
`endif

/* design/sep_pkg.sv */
`include "sep_cfg.svh"
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_IDLE  = 3'b000,
    SEP_HDR   = 3'b001,
    SEP_RDOUT = 3'b010,
    SEP_WDATA = 3'b011,
    SEP_ARMED = 3'b100,
    SEP_SKIP  = 3'b101
  } sep_state_e;

  typedef enum logic [1:0] {
    SEP_P_ERASE = 2'b00,
    SEP_P_WRITE = 2'b01,
    SEP_P_EALL  = 2'b10,
    SEP_P_WALL  = 2'b11
  } sep_prog_e;

  // Serial pins seen from the device
  typedef struct packed {
    logic cs;
    logic serial_clock;
    logic serial_in;
  } sep_pins_s;

  // Programming request to the array
  typedef struct packed {
    logic      go;
    sep_prog_e kind;
    logic [7:0] addr;
    logic [15:0] data;
  } sep_prog_s;
endpackage

/* design/sep_edge.sv */
module sep_edge (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic last;

  // Edge pulses from a level already synchronous to the clock
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      last <= 1'b0;
    end else begin
      last <= i_level;
    end
  end

  assign o_rise = i_level & ~last;
  assign o_fall = ~i_level & last;
endmodule

/* design/sep_array.sv */
`include "sep_cfg.svh"
module sep_array #(
  parameter int unsigned PROG_CYCLES = `SEP_PROG_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire sep_pkg::sep_prog_s i_prog,
  input  wire logic [7:0]        i_rd_addr,
  output logic [15:0]            o_rd_data,
  output logic                   o_busy
);
  import sep_pkg::*;

  logic [15:0] mem [`SEP_WORDS];
  logic [31:0] timer;
  sep_prog_s   held;

  // ****************************************************************
  // Self-timed cycle: contents change when the count expires
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer  <= 32'h0;
      o_busy <= 1'b0;
      held   <= '0;
    end else if (!o_busy && i_prog.go) begin
      held   <= i_prog;
      timer  <= PROG_CYCLES - 1;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      if (timer == 32'h0) begin
        o_busy <= 1'b0;
      end else begin
        timer <= timer - 32'h1;
      end
    end
  end

  // Array update at the end of the busy time; no reset, it is storage
  always_ff @(posedge i_core_clk) begin
    if (o_busy && timer == 32'h0) begin
      for (int i = 0; i < `SEP_WORDS; i++) begin
        case (held.kind)
          SEP_P_ERASE: if (held.addr == i[7:0]) mem[i] <= `SEP_ERASED;
          SEP_P_WRITE: if (held.addr == i[7:0]) mem[i] <= held.data;
          SEP_P_EALL:  mem[i] <= `SEP_ERASED;
          SEP_P_WALL:  mem[i] <= held.data;
          default:     mem[i] <= mem[i];
        endcase
      end
    end
  end

  assign o_rd_data = mem[i_rd_addr];
endmodule

/* design/sep_port.sv */
`include "sep_cfg.svh"
module sep_port #(
  parameter int unsigned PROG_CYCLES = `SEP_PROG_CYC
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst,
  input  wire sep_pkg::sep_pins_s i_pins,
  output logic                    o_serial_out,
  output logic                    o_serial_out_en,
  output logic                    o_prog_enabled,
  output logic                    o_busy
);
  import sep_pkg::*;

  sep_state_e  state;
  logic [9:0]  hdr;
  logic [3:0]  hdr_cnt;
  logic [4:0]  bit_cnt;
  logic [15:0] shreg;
  logic        sclk_rise;
  logic        cs_rise;
  logic        cs_fall;
  logic        status_mode;
  sep_prog_s   pending;
  sep_prog_s   prog_req;
  logic [15:0] rd_data;

  // Programming commands only arm when enabled; otherwise they are dropped
  function automatic sep_state_e arm_or_skip(input logic enabled);
    return enabled ? SEP_ARMED : SEP_SKIP;
  endfunction

  // ****************************************************************
  // Edge detection on the serial pins
  // ****************************************************************
  sep_edge u_sclk_edge (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_level    (i_pins.serial_clock),
    .o_rise     (sclk_rise),
    .o_fall     ()
  );

  sep_edge u_cs_edge (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_level    (i_pins.cs),
    .o_rise     (cs_rise),
    .o_fall     (cs_fall)
  );

  // ****************************************************************
  // Header decode
  // ****************************************************************
  wire [9:0] hdr_next  = {hdr[8:0], i_pins.serial_in};
  wire [1:0] op        = hdr_next[9:8];
  wire [7:0] addr      = hdr_next[7:0];
  wire [1:0] ext       = addr[7:6];
  wire       hdr_done  = (state == SEP_HDR) && sclk_rise &&
                         hdr_cnt == 4'(`SEP_HDR_BITS - 1);
  wire       is_read   = op == `SEP_OP_READ;
  wire       is_erase  = op == `SEP_OP_ERASE;
  wire       is_write  = op == `SEP_OP_WRITE;
  wire       is_ext    = op == `SEP_OP_EXT;
  wire       wr_done   = (state == SEP_WDATA) && sclk_rise &&
                         bit_cnt == 5'(`SEP_DATA_W - 1);
  // A fall of chip select only counts once the frame is fully armed
  wire       fire      = (state == SEP_ARMED) && cs_fall;

  assign prog_req = '{go: fire, kind: pending.kind,
                      addr: pending.addr, data: pending.data};

  sep_array #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_array (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_prog     (prog_req),
    .i_rd_addr  (addr),
    .o_rd_data  (rd_data),
    .o_busy     (o_busy)
  );

  // ****************************************************************
  // Frame state machine
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= SEP_IDLE;
      hdr     <= 10'h0;
      hdr_cnt <= 4'h0;
      bit_cnt <= 5'h0;
      pending <= '0;
    end else if (!i_pins.cs) begin
      state <= SEP_IDLE; // Chip select low aborts any frame
    end else begin
      case (state)
        SEP_IDLE: begin
          if (sclk_rise && i_pins.serial_in && !o_busy) begin
            state   <= SEP_HDR;
            hdr_cnt <= 4'h0;
          end
        end
        SEP_HDR: begin
          if (sclk_rise) begin
            hdr     <= hdr_next;
            hdr_cnt <= hdr_cnt + 4'h1;
          end
          if (hdr_done) begin
            pending.addr <= addr;
            bit_cnt      <= 5'h0;
            if (is_read) begin
              state <= SEP_RDOUT;
            end else if (is_erase) begin
              pending.kind <= SEP_P_ERASE;
              state <= arm_or_skip(o_prog_enabled);
            end else if (is_write) begin
              pending.kind <= SEP_P_WRITE;
              state <= SEP_WDATA;
            end else if (is_ext && ext == `SEP_EXT_EALL) begin
              pending.kind <= SEP_P_EALL;
              state <= arm_or_skip(o_prog_enabled);
            end else if (is_ext && ext == `SEP_EXT_WALL) begin
              pending.kind <= SEP_P_WALL;
              state <= SEP_WDATA;
            end else begin
              state <= SEP_SKIP;
            end
          end
        end
        SEP_WDATA: begin
          if (sclk_rise) begin
            pending.data <= {pending.data[14:0], i_pins.serial_in};
            bit_cnt      <= bit_cnt + 5'h1;
          end
          if (wr_done) begin
            state <= arm_or_skip(o_prog_enabled);
          end
        end
        SEP_RDOUT: state <= SEP_RDOUT;
        // A further rising clock edge after the last bit cancels the program
        SEP_ARMED: if (sclk_rise) state <= SEP_SKIP;
        SEP_SKIP:  state <= SEP_SKIP;
        default:   state <= SEP_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Program enable latch
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prog_enabled <= 1'b0;
    end else if (hdr_done && i_pins.cs && is_ext) begin
      if (ext == `SEP_EXT_EN) begin
        o_prog_enabled <= 1'b1;
      end else if (ext == `SEP_EXT_DIS) begin
        o_prog_enabled <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Data out: read shifter and ready/busy status
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg           <= 16'h0;
      o_serial_out    <= 1'b0;
      o_serial_out_en <= 1'b0;
      status_mode     <= 1'b0;
    end else if (!i_pins.cs) begin
      o_serial_out_en <= 1'b0;
      status_mode     <= o_busy || fire;
    end else if (cs_rise && status_mode) begin
      // Host raised chip select after a programming start
      o_serial_out_en <= 1'b1;
      o_serial_out    <= ~o_busy;
    end else if (status_mode && o_serial_out_en) begin
      o_serial_out <= ~o_busy;
      if (!o_busy && sclk_rise) begin
        status_mode     <= 1'b0;
        o_serial_out_en <= 1'b0;
      end
    end else if (hdr_done && is_read) begin
      shreg           <= rd_data;
      o_serial_out    <= 1'b0;
      o_serial_out_en <= 1'b1;
    end else if (state == SEP_RDOUT && sclk_rise) begin
      o_serial_out <= shreg[15];
      shreg        <= {shreg[14:0], 1'b0};
    end
  end
endmodule

/* verif/sep_port_sva.sv */
// ********************************
// Port checker
// ********************************
module sep_port_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic               i_core_clk,
  input wire logic               i_rst,
  input wire sep_pkg::sep_pins_s i_pins,
  input wire logic               o_serial_out,
  input wire logic               o_serial_out_en,
  input wire logic               o_prog_enabled,
  input wire logic               o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  import sep_pkg::*;
  int unsigned bcnt;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Busy run length, so a long cycle shows once it passes the count and a short one at its end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) bcnt <= 0;
    else bcnt <= o_busy ? bcnt + 1 : 0;
  end
  // Self-timed cycle and its status
  chk_busy_span: assert property (
    $fell(o_busy) |-> bcnt == PROG_CYCLES) else $error("busy span wrong");
  chk_busy_bound: assert property (
    o_busy |-> bcnt < PROG_CYCLES) else $error("busy too long");
  chk_busy_start: assert property (
    $rose(o_busy) |-> !$past(i_pins.cs)) else $error("busy without cs fall");
  chk_no_prog_off: assert property (
    $rose(o_busy) |-> $past(o_prog_enabled)) else $error("busy when off");
  chk_status_low: assert property (
    o_serial_out_en && $past(o_serial_out_en) && $past(o_busy) && o_busy
    |-> !o_serial_out) else $error("busy not shown low");
  chk_status_ready: assert property (
    o_serial_out_en && $fell(o_busy) |-> ##[0:2] o_serial_out)
    else $error("ready not shown high");
  // Data out timing and enable
  chk_out_on_rise: assert property (
    o_serial_out_en && $past(o_serial_out_en) && $changed(o_serial_out)
    && !$past(o_busy) && !$past(o_busy, 2) && !$past(o_busy, 3)
    |-> $past(i_pins.serial_clock)) else $error("out moved off a rise");
  chk_dummy_zero: assert property (
    $rose(o_serial_out_en) && $past(i_pins.serial_clock) |-> !o_serial_out)
    else $error("dummy bit not zero");
  chk_en_drop: assert property (
    !i_pins.cs && !$past(i_pins.cs) |-> !o_serial_out_en)
    else $error("out enabled without cs");
  chk_off_by_cmd: assert property (
    $fell(o_prog_enabled) |-> $past(i_pins.cs)) else $error("enable lost");
  cover property ($rose(o_busy));
  cover property ($rose(o_serial_out_en) && $past(i_pins.serial_clock));
  cover property ($fell(o_prog_enabled));
endmodule

/* verif/sep_host.sv */
// ********************************
// Host model on the serial bus
// ********************************
module sep_host (
  input  wire logic          i_clk,
  input  wire logic          i_dout,
  output sep_pkg::sep_pins_s o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import sep_pkg::*;
  logic [15:0] obs;
  event        got;
  int          seed = 39293;
  initial o_pins = '0;
  // One serial clock period; samples data out just before the rise
  task automatic bit_cyc(input logic b, output logic q);
    q = i_dout;
    o_pins.serial_in = b;
    @(negedge i_clk);
    o_pins.serial_clock = 1'b1;
    repeat (3) @(negedge i_clk);
    o_pins.serial_clock = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  // Start bit after random idle zeros, header, then data if asked
  task automatic frame(input logic [1:0] op, input logic [7:0] a,
                       input logic [15:0] d);
    logic       q;
    logic [9:0] h;
    h = {op, a};
    o_pins.cs = 1'b1;
    repeat ($random(seed) & 3) bit_cyc(1'b0, q);
    bit_cyc(1'b1, q);
    for (int i = 9; i >= 0; i--) bit_cyc(h[i], q);
    if (op == 2'h1 || h[9:6] == 4'h1)
      for (int i = 15; i >= 0; i--) bit_cyc(d[i], q);
  endtask
  // Drop cs with the clock low; released input is not left stable
  task automatic done();
    o_pins.cs = 1'b0;
    o_pins.serial_in = ~o_pins.serial_in;
    repeat (63) @(negedge i_clk);
  endtask
  // Read: dummy bit shifts out of the window, sixteen data bits remain
  task automatic rd(input logic [7:0] a);
    logic q;
    frame(2'h2, a, 16'h0);
    for (int i = 0; i < 17; i++) begin
      bit_cyc(1'($random(seed)), q);
      obs = {obs[14:0], q};
    end
    ->got;
    done();
  endtask
  // Status poll with bounded wait for ready
  task automatic status(output bit ok);
    logic q;
    o_pins.cs = 1'b1;
    repeat (3) @(negedge i_clk);
    obs = {15'h0, i_dout};
    ->got;
    ok = 0;
    for (int n = 0; n < 400 && !ok; n++) begin
      @(negedge i_clk);
      ok = i_dout === 1'b1;
    end
    bit_cyc(1'b0, q);
    done();
  endtask
endmodule

/* verif/sep_port_tb.sv */
// ********************************
// Bench top
// ********************************
module sep_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sep_pkg::*;
  localparam int unsigned PC = 200;
  logic        clk, rst, out, en, pe, busy;
  wire         dout;
  sep_pins_s   pins;
  logic [15:0] exp_q[$];
  logic [15:0] v, p;
  int          errors = 0;
  int          num_checks = 0;
  // Data out pin floats when the device lets go of it
  assign dout = en ? out : 1'bz;
  sep_port #(.PROG_CYCLES(PC)) uut (
    .i_core_clk     (clk),
    .i_rst          (rst),
    .i_pins         (pins),
    .o_serial_out   (out),
    .o_serial_out_en(en),
    .o_prog_enabled (pe),
    .o_busy         (busy)
  );
  sep_host u_host (.i_clk(clk), .i_dout(dout), .o_pins(pins));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Helpers
  function automatic logic [15:0] rnd();
    return 16'($random(u_host.seed));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] a,
                     input logic [15:0] d);
    u_host.frame(op, a, d);
    u_host.done();
  endtask
  // Programming command followed by a status poll
  task automatic prog(input logic [1:0] op, input logic [7:0] a,
                      input logic [15:0] d);
    bit ok;
    cmd(op, a, d);
    exp_q.push_back(16'h0);
    u_host.status(ok);
    if (!ok) begin
      errors++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  // Write with one serial clock rise too many after its last data bit
  task automatic late_cs(input logic [7:0] a, input logic [15:0] d);
    logic q;
    u_host.frame(2'h1, a, d);
    u_host.bit_cyc(1'b0, q);
    u_host.done();
  endtask
  // Scoreboard: each host observation against the oldest note
  always @(u_host.got) check(u_host.obs, exp_q.pop_front());
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    v = rnd();
    check({15'h0, pe}, 16'h0);
    cmd(2'h1, 8'h05, 16'h1234);
    check({15'h0, busy}, 16'h0);
    cmd(2'h0, {2'h3, v[5:0]}, 16'h0);
    check({15'h0, pe}, 16'h1);
    prog(2'h0, {2'h2, v[5:0]}, 16'h0);
    rd(8'h00, 16'hFFFF);
    rd(8'hFF, 16'hFFFF);
    repeat (4) begin
      v = rnd();
      p = rnd();
      prog(2'h1, v[7:0], p);
      rd(v[7:0], p);
    end
    prog(2'h3, v[7:0], 16'h0);
    rd(v[7:0], 16'hFFFF);
    p = rnd();
    prog(2'h0, {2'h1, v[13:8]}, p);
    rd(v[15:8], p);
    check({15'h0, pe}, 16'h1);
    late_cs(v[7:0], ~p);
    check({15'h0, busy}, 16'h0);
    cmd(2'h0, {2'h0, v[5:0]}, 16'h0);
    check({15'h0, pe}, 16'h0);
    cmd(2'h1, v[7:0], ~p);
    cmd(2'h3, v[15:8], 16'h0);
    cmd(2'h0, 8'h80, 16'h0);
    cmd(2'h0, 8'h5A, ~p);
    check({15'h0, busy}, 16'h0);
    rd(v[7:0], p);
    rd(v[15:8], p);
    // Reset in mid-run drops the enable but keeps the stored words
    cmd(2'h0, 8'hC0, 16'h0);
    check({15'h0, pe}, 16'h1);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({15'h0, pe}, 16'h0);
    check({15'h0, busy}, 16'h0);
    rd(v[7:0], p);
    results();
  end
endmodule
bind sep_port sep_port_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .i_core_clk, .i_rst, .i_pins, .o_serial_out, .o_serial_out_en,
  .o_prog_enabled, .o_busy
);
